// [core/sac_pkg.sv]
package sac_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] SAC_CSR_ADDR = 8'h3c;
  localparam logic [7:0] SAC_DATA_ADDR = 8'h40;
  localparam logic [7:0] SAC_CLK_ADDR = 8'h44;
  localparam logic [7:0] SAC_PORT_DATA_ADDR = 8'h48;
  localparam logic [7:0] SAC_PORT_DIR_ADDR = 8'h4c;
  localparam logic [7:0] SAC_PORT_PIN_ADDR = 8'h50;

  // control/status field positions
  localparam int SAC_DONE_BIT = 7;
  localparam int SAC_IRQEN_BIT = 6;
  localparam int SAC_REPEAT_BIT = 5;
  localparam int SAC_CH_MSB = 4;
  localparam int SAC_CH_W = 5;
  localparam logic [4:0] SAC_CH_OFF = 5'h1f;

  // clock register prescale field
  localparam int SAC_PRESC_MSB = 7;
  localparam int SAC_PRESC_LSB = 5;
  localparam int SAC_PRESC_W = 3;
  localparam logic [2:0] SAC_PRESC_RST = 3'h0;

  // shared port pins and result width
  localparam int SAC_PINS = 4;
  localparam int SAC_RES_W = 8;
  localparam logic [7:0] SAC_SAR_INIT = 8'h80;

  // conversion timing in converter clocks
  localparam logic [3:0] SAC_CONV_LAST = 4'hf;
  localparam logic [3:0] SAC_CONV_FIRST = 4'h1;
  localparam logic [3:0] SAC_DECIDE_FROM = 4'h8;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_ARMED,
    SAC_CONVERT
  } sac_state_t;
endpackage : sac_pkg

// [core/sac_tick_gen.sv]
// converter clock: one-cycle tick per divided period of ref_clk
module sac_tick_gen
  import sac_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [SAC_PRESC_W-1:0] prescale,
  // converter clock rising edge
  output logic tick
);

  logic [3:0] div_cnt;
  logic [3:0] limit;

  // divide by 1, 2, 4, 8, or 16 when the top bit is set
  function automatic logic [3:0] div_limit(input logic [SAC_PRESC_W-1:0] code);
    logic [3:0] lim;
    lim = 4'hf;
    unique case (code)
      3'h0: lim = 4'h0;
      3'h1: lim = 4'h1;
      3'h2: lim = 4'h3;
      3'h3: lim = 4'h7;
      default: lim = 4'hf;
    endcase
    return lim;
  endfunction : div_limit

  assign limit = div_limit(prescale);

  // >= keeps a shortened ratio from wrapping through sixteen counts
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      div_cnt <= 4'h0;
      tick <= 1'b0;
    end else if (div_cnt >= limit) begin
      div_cnt <= 4'h0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      tick <= 1'b0;
    end
  end

  a_tick_gap_div: assert property (@(posedge ref_clk) disable iff (rst)
    (tick && limit != 4'h0 && $stable(prescale)) |=> !tick)
    else $error("converter tick repeated with divide ratio above one");

  a_tick_stopped: assert property (@(posedge ref_clk) disable iff (rst)
    !run |=> !tick)
    else $error("converter tick while halted");
endmodule : sac_tick_gen

// [core/sac_conv_ctrl.sv]
// Overview of operation
// - each conversion lasts sixteen converter clocks
// - start on first converter edge after write
// - load 8-bit result, then flag or interrupt
// - channel field picks one of four pins
// - selected pin forced to input
// - port writes ignore the selected pin
// - selected pin reads zero or data latch
// - repeat mode overwrites result every conversion
// - clearing repeat restarts one last conversion
// - polled flag set, cleared by data read
// - interrupt mode requests irq, flag stays zero
// - stop mode aborts, resumes after exit
// - five-bit channel field, all ones off
// - data read or control write clears irq
// - prescale divides by 1,2,4,8 or 16
module sac_conv_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power mode from the system controller
  input wire logic stop_mode,
  // analog front end
  input wire logic cmp_in,
  output logic [SAC_RES_W-1:0] dac_code,
  output logic [SAC_CH_W-1:0] chan_sel,
  // shared port pins 0, 1, 4, 5 in that order
  input wire logic [SAC_PINS-1:0] pin_in,
  output logic [SAC_PINS-1:0] pin_out,
  output logic [SAC_PINS-1:0] pin_oe_n,
  // conversion interrupt, level
  output logic conv_irq
);

  sac_state_t state;
  logic [3:0] conv_cnt;
  logic [SAC_RES_W-1:0] sar;
  logic [SAC_RES_W-1:0] next_sar;
  logic [SAC_RES_W-1:0] data_q;
  logic done_flag;
  logic conv_end;
  logic irq_en;
  logic repeat_on;
  logic [SAC_PRESC_W-1:0] prescale;
  logic [SAC_PINS-1:0] port_latch;
  logic [SAC_PINS-1:0] port_dir;
  logic [SAC_PINS-1:0] pin_meta;
  logic [SAC_PINS-1:0] pin_sync;
  logic cmp_meta;
  logic cmp_sync;
  logic tick;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic csr_wr;
  logic data_rd;
  logic finish;
  logic [SAC_PINS-1:0] sel_pins;
  logic [SAC_PINS-1:0] port_view;
  logic [2:0] bit_pos;

  // one-hot pin owned by the converter; other codes own no pin
  function automatic logic [SAC_PINS-1:0] port_sel(input logic [SAC_CH_W-1:0] ch);
    logic [SAC_PINS-1:0] oh;
    oh = '0;
    if (ch < 5'(SAC_PINS)) begin
      oh[ch[1:0]] = 1'b1;
    end
    return oh;
  endfunction : port_sel

  // keep or drop the trial bit, then try the next lower one
  function automatic logic [SAC_RES_W-1:0] sar_step(input logic [SAC_RES_W-1:0] cur,
                                                   input logic [2:0] pos, input logic above);
    logic [SAC_RES_W-1:0] nxt;
    nxt = cur;
    if (!above) begin
      nxt[pos] = 1'b0;
    end
    if (pos != 3'h0) begin
      nxt[pos - 3'h1] = 1'b1;
    end
    return nxt;
  endfunction : sar_step

  // the comparator and the pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      cmp_meta <= cmp_in;
      cmp_sync <= cmp_meta;
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // the divider runs whenever a channel is selected and stop mode is off
  sac_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(!stop_mode && chan_sel != SAC_CH_OFF),
    .prescale(prescale),
    .tick(tick)
  );

  // apb strobes: a transfer completes on the edge that sees pready
  assign acc_done = psel && penable && pready;
  assign wr_done = acc_done && pwrite;
  assign rd_done = acc_done && !pwrite;
  assign csr_wr = wr_done && paddr == SAC_CSR_ADDR;
  assign data_rd = rd_done && paddr == SAC_DATA_ADDR;

  // conversion step: decisions occupy the last eight converter clocks
  assign bit_pos = 3'(SAC_CONV_LAST - conv_cnt);
  // decide only on a converter edge, so the dac holds the trial code steady in between
  assign next_sar = (tick && conv_cnt >= SAC_DECIDE_FROM) ? sar_step(sar, bit_pos, cmp_sync) : sar;
  assign finish = state == SAC_CONVERT && tick && conv_cnt == SAC_CONV_LAST &&
                  !csr_wr && !stop_mode;
  assign sel_pins = port_sel(chan_sel);

  // conversion sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= SAC_IDLE;
      conv_cnt <= 4'h0;
      sar <= '0;
    end else if (csr_wr) begin
      // a write restarts; the interrupted result is never loaded
      conv_cnt <= 4'h0;
      if (pwdata[SAC_CH_MSB:0] == SAC_CH_OFF) begin
        state <= SAC_IDLE;
      end else begin
        state <= SAC_ARMED;
      end
    end else if (stop_mode) begin
      // abort but stay armed so conversions resume after exit
      conv_cnt <= 4'h0;
      if (state == SAC_CONVERT) begin
        state <= SAC_ARMED;
      end
    end else if (tick) begin
      unique case (state)
        SAC_IDLE: begin
          conv_cnt <= 4'h0;
        end
        SAC_ARMED: begin
          // this edge is the first of the sixteen
          state <= SAC_CONVERT;
          conv_cnt <= SAC_CONV_FIRST;
          sar <= SAC_SAR_INIT;
        end
        SAC_CONVERT: begin
          if (conv_cnt == SAC_CONV_LAST) begin
            conv_cnt <= 4'h0;
            sar <= SAC_SAR_INIT;
            if (!repeat_on) begin
              state <= SAC_IDLE;
            end
          end else begin
            conv_cnt <= conv_cnt + 4'h1;
            sar <= next_sar;
          end
        end
        default: begin
          state <= SAC_IDLE;
        end
      endcase
    end
  end

  // result and completion events; a new event wins over its clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_q <= '0;
      done_flag <= 1'b0;
      conv_irq <= 1'b0;
      conv_end <= 1'b0;
    end else begin
      conv_end <= finish;
      if (finish) begin
        data_q <= next_sar;
      end
      if (finish && !irq_en) begin
        done_flag <= 1'b1;
      end else if (data_rd || (csr_wr && pwdata[SAC_IRQEN_BIT])) begin
        done_flag <= 1'b0;
      end
      if (finish && irq_en) begin
        conv_irq <= 1'b1;
      end else if (data_rd || csr_wr) begin
        conv_irq <= 1'b0;
      end
    end
  end

  // software controls; the done bit position ignores writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_en <= 1'b0;
      repeat_on <= 1'b0;
      chan_sel <= SAC_CH_OFF;
      prescale <= SAC_PRESC_RST;
    end else if (wr_done) begin
      if (paddr == SAC_CSR_ADDR) begin
        irq_en <= pwdata[SAC_IRQEN_BIT];
        repeat_on <= pwdata[SAC_REPEAT_BIT];
        chan_sel <= pwdata[SAC_CH_MSB:0];
      end
      if (paddr == SAC_CLK_ADDR) begin
        prescale <= pwdata[SAC_PRESC_MSB:SAC_PRESC_LSB];
      end
    end
  end

  // port logic for the shared pins; the converter's pin keeps its bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_latch <= '0;
      port_dir <= '0;
    end else if (wr_done) begin
      if (paddr == SAC_PORT_DATA_ADDR) begin
        port_latch <= (pwdata[SAC_PINS-1:0] & ~sel_pins) | (port_latch & sel_pins);
      end
      if (paddr == SAC_PORT_DIR_ADDR) begin
        port_dir <= (pwdata[SAC_PINS-1:0] & ~sel_pins) | (port_dir & sel_pins);
      end
    end
  end

  // pin drivers: the converter's pin is released whatever the direction says
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
      dac_code <= '0;
    end else begin
      pin_out <= port_latch;
      pin_oe_n <= ~(port_dir & ~sel_pins);
      dac_code <= next_sar; // comparator reply needs three cycles: exact results from divide by four up
    end
  end

  // port read view: converter pin gives 0 or the latch, never the pad
  always_comb begin
    for (int i = 0; i < SAC_PINS; i++) begin
      if (port_dir[i]) begin
        port_view[i] = port_latch[i];
      end else if (sel_pins[i]) begin
        port_view[i] = 1'b0;
      end else begin
        port_view[i] = pin_sync[i];
      end
    end
  end

  // apb answer: one wait state, data and error ready with pready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= '0;
      unique case (paddr)
        SAC_CSR_ADDR: prdata[SAC_DONE_BIT:0] <= {done_flag && !irq_en, irq_en, repeat_on, chan_sel};
        SAC_DATA_ADDR: prdata[SAC_RES_W-1:0] <= data_q;
        SAC_CLK_ADDR: prdata[SAC_PRESC_MSB:SAC_PRESC_LSB] <= prescale;
        SAC_PORT_DATA_ADDR: prdata[SAC_PINS-1:0] <= port_view;
        SAC_PORT_DIR_ADDR: prdata[SAC_PINS-1:0] <= port_dir;
        SAC_PORT_PIN_ADDR: prdata[SAC_PINS-1:0] <= pin_sync;
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  a_start_on_tick: assert property (@(posedge ref_clk) disable iff (rst)
    (state == SAC_ARMED && tick && !csr_wr && !stop_mode)
    |=> (state == SAC_CONVERT && conv_cnt == SAC_CONV_FIRST))
    else $error("conversion did not start on converter edge");

  a_write_rearms: assert property (@(posedge ref_clk) disable iff (rst)
    (csr_wr && pwdata[SAC_CH_MSB:0] != SAC_CH_OFF) |=> state == SAC_ARMED)
    else $error("control write did not rearm the converter");

  a_result_load: assert property (@(posedge ref_clk) disable iff (rst)
    finish |=> (conv_end && data_q == $past(next_sar)))
    else $error("result not loaded at end of conversion");

  a_conv_length: assert property (@(posedge ref_clk) disable iff (rst)
    conv_end |-> ($past(conv_cnt) == SAC_CONV_LAST && $past(state) == SAC_CONVERT))
    else $error("conversion ended before sixteen converter clocks");

  a_done_polled: assert property (@(posedge ref_clk) disable iff (rst)
    (finish && !irq_en) |=> (done_flag && !conv_irq))
    else $error("polled completion flag not set");

  a_irq_mode: assert property (@(posedge ref_clk) disable iff (rst)
    (finish && irq_en && !done_flag) |=> (conv_irq && !done_flag))
    else $error("interrupt mode did not raise request alone");

  a_read_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (data_rd && !finish) |=> (!conv_irq && !done_flag))
    else $error("data read did not clear completion");

  a_repeat_chain: assert property (@(posedge ref_clk) disable iff (rst)
    (finish && repeat_on) |=> (state == SAC_CONVERT && conv_cnt == 4'h0))
    else $error("repeat mode did not chain the next conversion");

  a_single_stops: assert property (@(posedge ref_clk) disable iff (rst)
    (finish && !repeat_on) |=> state == SAC_IDLE)
    else $error("single conversion did not stop");

  a_stop_abort: assert property (@(posedge ref_clk) disable iff (rst)
    (stop_mode && !csr_wr) |=> (state != SAC_CONVERT && !conv_end))
    else $error("conversion kept running in stop mode");

  a_off_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (chan_sel == SAC_CH_OFF) |-> (state == SAC_IDLE && !finish))
    else $error("converter active with power-off code");

  a_pin_released: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ((port_sel($past(chan_sel)) & ~pin_oe_n) == '0))
    else $error("selected pin is being driven");
endmodule : sac_conv_ctrl

// [test/sac_front_model.sv]
// analog mux, comparator and pads seen by the converter control
module sac_front_model
  import sac_pkg::*;
(
  // analog side
  input wire logic [SAC_CH_W-1:0] chan_sel,
  input wire logic [SAC_RES_W-1:0] dac_code,
  output logic cmp_in,
  // shared pads
  input wire logic [SAC_PINS-1:0] pin_out,
  input wire logic [SAC_PINS-1:0] pin_oe_n,
  output logic [SAC_PINS-1:0] pin_in,
  // levels chosen by the bench
  input wire logic [SAC_PINS-1:0][SAC_RES_W-1:0] level,
  input wire logic [SAC_PINS-1:0] ext_pad
);
  timeunit 1ns;
  timeprecision 100ps;

  // input sits half a step above its code, so a sar search lands on it exactly
  always_comb begin
    if (chan_sel < 5'h04) begin
      cmp_in = (level[chan_sel[1:0]] >= dac_code);
    end else begin
      cmp_in = dac_code[0]; // no pin behind it, output carries no meaning
    end
  end

  // a released pad shows the outside level, a driven one the latch
  always_comb begin
    for (int i = 0; i < SAC_PINS; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_pad[i] : pin_out[i];
    end
  end
endmodule : sac_front_model

// [test/tb_sac_conv_ctrl.sv]
module tb_sac_conv_ctrl
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_mode = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, cmp_in, conv_irq, e;
  logic [SAC_RES_W-1:0] dac_code;
  logic [SAC_CH_W-1:0] chan_sel;
  logic [SAC_PINS-1:0] pin_in, pin_out, pin_oe_n;
  logic [SAC_PINS-1:0][SAC_RES_W-1:0] level = {8'h11, 8'h22, 8'ha5, 8'h5a};
  logic [SAC_PINS-1:0] ext_pad = 4'h3;
  int n_fail = 0, n_checks = 0, cyc = 0, c;

  sac_conv_ctrl sac_conv_ctrl_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_mode(stop_mode), .cmp_in(cmp_in), .dac_code(dac_code),
    .chan_sel(chan_sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .conv_irq(conv_irq));

  sac_front_model sac_front_model_i (.chan_sel(chan_sel), .dac_code(dac_code), .cmp_in(cmp_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in), .level(level), .ext_pad(ext_pad));

  // 200 mhz reference clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic test_done();
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // hang guard, well above the few thousand cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, v, lo, hi);
    end
  endtask : chk_rng

  // one apb transfer; an idle edge follows so a next setup never reuses this time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait states are the slave's business; only the hang guard ends a stuck wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, d, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp);
  endtask : rdc

  // poll the status register until the done flag shows
  task automatic wait_done();
    c = 0;
    do begin
      apb(1'b0, SAC_CSR_ADDR, 32'h0, d, e);
      c++;
    end while (d[SAC_DONE_BIT] !== 1'b1 && c < 100);
    chk_rng(c, 1, 99);
  endtask : wait_done

  // cycles from the idle edge that ends the last write until the irq shows;
  // sampled on the edge itself so the next transfer starts right after it
  task automatic wait_irq();
    c = 0;
    while (conv_irq !== 1'b1 && c < 400) begin
      @(posedge ref_clk);
      c++;
    end
  endtask : wait_irq

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, 8'h54, 32'h0, d, e);
    chk(32'(e), 32'h1);
    chk(d, 32'h0);
    repeat (40) @(posedge ref_clk);
    chk(32'(conv_irq), 32'h0);
    rdc(SAC_CSR_ADDR, 32'h1f);
    rdc(SAC_CLK_ADDR, 32'h0);
    // port ownership of the selected pin
    wr(SAC_PORT_DIR_ADDR, 32'hf);
    wr(SAC_PORT_DATA_ADDR, 32'h5);
    wr(SAC_CSR_ADDR, 32'h02);
    repeat (2) @(posedge ref_clk);
    chk(32'(pin_oe_n), 32'h4);
    chk(32'(chan_sel), 32'h2);
    wr(SAC_PORT_DATA_ADDR, 32'ha);
    wr(SAC_PORT_DIR_ADDR, 32'h0);
    chk(32'(pin_out), 32'he);
    rdc(SAC_PORT_DIR_ADDR, 32'h4);
    rdc(SAC_PORT_DATA_ADDR, 32'h7);
    wr(SAC_CSR_ADDR, 32'h00);
    rdc(SAC_PORT_DATA_ADDR, 32'h6);
    // every prescale code in interrupt mode
    for (int p = 0; p < 8; p++) begin
      wr(SAC_CLK_ADDR, 32'(p) << SAC_PRESC_LSB);
      wr(SAC_CSR_ADDR, 32'h40);
      wait_irq();
      chk_rng(c, 15 * (p < 4 ? 1 << p : 16) + 1, 16 * (p < 4 ? 1 << p : 16));
      rdc(SAC_CSR_ADDR, 32'h40);
      apb(1'b0, SAC_DATA_ADDR, 32'h0, d, e);
      chk(32'(conv_irq), 32'h0);
    end
    wr(SAC_CSR_ADDR, 32'h40);
    wait_irq();
    wr(SAC_CSR_ADDR, 32'h1f);
    chk(32'(conv_irq), 32'h0);
    // polled single conversion on pin one
    wr(SAC_CLK_ADDR, 32'h40);
    wr(SAC_CSR_ADDR, 32'h01);
    wait_done();
    repeat (20) @(posedge ref_clk);
    rdc(SAC_CSR_ADDR, 32'h81);
    chk(32'(conv_irq), 32'h0);
    rdc(SAC_DATA_ADDR, 32'ha5);
    rdc(SAC_CSR_ADDR, 32'h01);
    // repeat mode, then leave it
    wr(SAC_CSR_ADDR, 32'h21);
    wait_done();
    level[1] <= 8'h3c;
    repeat (200) @(posedge ref_clk);
    rdc(SAC_DATA_ADDR, 32'h3c);
    wr(SAC_CSR_ADDR, 32'h01);
    // a flag from the last repeat result may still stand; drop it before polling
    apb(1'b0, SAC_DATA_ADDR, 32'h0, d, e);
    wait_done();
    apb(1'b0, SAC_DATA_ADDR, 32'h0, d, e);
    repeat (200) @(posedge ref_clk);
    rdc(SAC_CSR_ADDR, 32'h01);
    // stop aborts, conversion resumes after exit
    wr(SAC_CSR_ADDR, 32'h40);
    stop_mode <= 1'b1;
    repeat (200) @(posedge ref_clk);
    chk(32'(conv_irq), 32'h0);
    stop_mode <= 1'b0;
    wait_irq();
    chk_rng(c, 49, 72);
    apb(1'b0, SAC_DATA_ADDR, 32'h0, d, e);
    wr(SAC_CSR_ADDR, 32'h1f);
    test_done();
  end
endmodule : tb_sac_conv_ctrl
